// >>> rtl/qdrpc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz system clock
// Notes: Included by the control block, the host model and the testbench
`ifndef QDRPC_CFG_SVH
`define QDRPC_CFG_SVH

// Register byte offsets
`define QDRPC_OFS_CMD 5'h00
`define QDRPC_OFS_STAT 5'h04
`define QDRPC_OFS_CH0 5'h08
`define QDRPC_OFS_CH1 5'h0c
`define QDRPC_OFS_CH2 5'h10
`define QDRPC_OFS_CH3 5'h14

// Command word fields
`define QDRPC_CODE_HI 23
`define QDRPC_CODE_LO 20
`define QDRPC_CHAN_HI 19
`define QDRPC_CHAN_LO 16

// Command codes
`define QDRPC_CMD_WRITE 4'h0
`define QDRPC_CMD_UPDATE 4'h1
`define QDRPC_CMD_WRITE_UPD_ALL 4'h2
`define QDRPC_CMD_WRITE_UPD 4'h3
`define QDRPC_CMD_PD_CHAN 4'h4
`define QDRPC_CMD_PD_CHIP 4'h5
`define QDRPC_CMD_REF_INT 4'h6
`define QDRPC_CMD_REF_EXT 4'h7
`define QDRPC_CMD_NOP 4'hf
`define QDRPC_CHAN_ALL 4'hf
`define QDRPC_CHAN_LAST 4'h3

// Reset values
`define QDRPC_RST_CODE 16'h0000
`define QDRPC_RST_CMD 24'h000000

// Power-up delays
`define QDRPC_CLK_NS 20
`define QDRPC_PWRUP_NS 10000
`define QDRPC_PWRUP_BIAS_NS 12000
`define QDRPC_PWRUP_CYC ((`QDRPC_PWRUP_NS + `QDRPC_CLK_NS - 1) / `QDRPC_CLK_NS)
`define QDRPC_PWRUP_BIAS_CYC ((`QDRPC_PWRUP_BIAS_NS + `QDRPC_CLK_NS - 1) / `QDRPC_CLK_NS)

`endif

// >>> rtl/qdrpc_pkg.sv
// Purpose: Types of the converter control block
// Assumes: Nothing
// Notes: Constants live in qdrpc_cfg.svh
package qdrpc_pkg;
  typedef logic [15:0] qdrpc_word_t;
  typedef logic [3:0] qdrpc_nib_t;
  typedef logic [9:0] qdrpc_cnt_t;
  // Which command last shut the reference off
  typedef enum logic {QDRPC_SRC_EXT, QDRPC_SRC_CHIP} qdrpc_refsrc_t;
endpackage : qdrpc_pkg

// >>> rtl/qdrpc_top.sv
// Purpose: Reference and power control of a quad voltage-output converter
// Assumes: Commands arrive as 24-bit words over Avalon-MM
// Notes: Options are picked by parameters at build time
`include "qdrpc_cfg.svh"

module qdrpc_top import qdrpc_pkg::*; #(
  parameter logic POR_EXT_REF = 1'b0,
  parameter logic POR_OPEN_OUT = 1'b0,
  parameter qdrpc_word_t POR_CODE = `QDRPC_RST_CODE
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Load pin
  input wire logic ASYNC_LOAD_N,
  // Analog control
  output logic [63:0] ACTIVE_CODE,
  output logic [3:0] CH_DRIVE,
  output logic REF_DRIVE,
  output logic REF_EXT,
  output logic BIAS_ON,
  output logic SETTLE_BUSY
);

  localparam int SHORT_CYC = `QDRPC_PWRUP_CYC;
  localparam int LONG_CYC = `QDRPC_PWRUP_BIAS_CYC;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // Bus slave state
  logic resp, next_resp;
  logic [31:0] rdata, next_rdata;
  logic [23:0] last_cmd, next_last_cmd;
  logic [31:0] rd_mux;
  logic cmd_go;

  // Load pin synchroniser
  logic ld_s1, ld_s2, ld_s3, ld_n;
  logic next_ld_s1, next_ld_s2, next_ld_s3, next_ld_n;
  logic load_act;

  // Command decode
  qdrpc_nib_t code, chan, mask, upd_v, pdm, pd_vec;
  qdrpc_word_t cmd_data;
  logic chan_ok, code_ok, exec, wr_in;

  // Per channel state
  qdrpc_word_t in_reg [4];
  qdrpc_word_t act [4];
  logic pd [4];
  qdrpc_word_t next_in [4];
  qdrpc_word_t next_act [4];
  logic next_pd [4];

  // Reference and settle state
  logic ref_ext, ref_on, next_ref_ext, next_ref_on;
  qdrpc_refsrc_t ref_src, next_ref_src;
  qdrpc_cnt_t settle, next_settle;
  logic wake, all_off;

  // One wait state per access
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !resp;
  assign AVS_READDATA = rdata;
  assign cmd_go = AVS_WRITE && resp && (AVS_ADDRESS == `QDRPC_OFS_CMD)
                  && (AVS_BYTEENABLE[2:0] == 3'h7);

  always_comb begin
    rd_mux = 32'h00000000;
    case (AVS_ADDRESS)
      `QDRPC_OFS_CMD: rd_mux = {8'h00, last_cmd};
      `QDRPC_OFS_STAT: rd_mux = {23'h000000, !ld_n, SETTLE_BUSY, BIAS_ON, ref_on, ref_ext,
                                 pd_vec};
      `QDRPC_OFS_CH0: rd_mux = {act[0], in_reg[0]};
      `QDRPC_OFS_CH1: rd_mux = {act[1], in_reg[1]};
      `QDRPC_OFS_CH2: rd_mux = {act[2], in_reg[2]};
      `QDRPC_OFS_CH3: rd_mux = {act[3], in_reg[3]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    next_resp = (AVS_READ || AVS_WRITE) && !resp;
    next_rdata = rdata;
    next_last_cmd = last_cmd;
    if (AVS_READ && !resp) begin
      next_rdata = rd_mux;
    end
    if (exec) begin
      next_last_cmd = AVS_WRITEDATA[23:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      resp <= 1'b0;
      rdata <= 32'h00000000;
      last_cmd <= `QDRPC_RST_CMD;
    end else begin
      resp <= next_resp;
      rdata <= next_rdata;
      last_cmd <= next_last_cmd;
    end
  end

  a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && !resp |=> !AVS_WAITREQUEST
    || !(AVS_READ || AVS_WRITE))
    else $error("access not answered after one wait state");

  // Pin filter reads only the second and third stages
  always_comb begin
    next_ld_s1 = ASYNC_LOAD_N;
    next_ld_s2 = ld_s1;
    next_ld_s3 = ld_s2;
    next_ld_n = (ld_s2 == ld_s3) ? ld_s3 : ld_n;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ld_s1 <= 1'b1;
      ld_s2 <= 1'b1;
      ld_s3 <= 1'b1;
      ld_n <= 1'b1;
    end else begin
      ld_s1 <= next_ld_s1;
      ld_s2 <= next_ld_s2;
      ld_s3 <= next_ld_s3;
      ld_n <= next_ld_n;
    end
  end

  assign load_act = !ld_n;

  // Command word layout
  assign code = AVS_WRITEDATA[`QDRPC_CODE_HI:`QDRPC_CODE_LO];
  assign chan = AVS_WRITEDATA[`QDRPC_CHAN_HI:`QDRPC_CHAN_LO];
  assign cmd_data = AVS_WRITEDATA[15:0];
  assign chan_ok = (chan <= `QDRPC_CHAN_LAST) || (chan == `QDRPC_CHAN_ALL);
  assign code_ok = (code <= `QDRPC_CMD_REF_EXT) || (code == `QDRPC_CMD_NOP);
  assign exec = cmd_go && chan_ok && code_ok;
  assign mask = (chan == `QDRPC_CHAN_ALL) ? 4'hf : (4'h1 << chan[1:0]);

  always_comb begin
    wr_in = 1'b0;
    upd_v = 4'h0;
    pdm = 4'h0;
    if (exec) begin
      case (code)
        `QDRPC_CMD_WRITE: wr_in = 1'b1;
        `QDRPC_CMD_UPDATE: upd_v = mask;
        `QDRPC_CMD_WRITE_UPD_ALL: begin
          wr_in = 1'b1;
          upd_v = 4'hf;
        end
        `QDRPC_CMD_WRITE_UPD: begin
          wr_in = 1'b1;
          upd_v = mask;
        end
        `QDRPC_CMD_PD_CHAN: pdm = mask;
        `QDRPC_CMD_PD_CHIP: pdm = 4'hf;
        default: wr_in = 1'b0;
      endcase
    end
    if (load_act) begin
      upd_v = 4'hf;
    end
  end

  // Per channel registers and power state
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      always_comb begin
        next_in[gi] = in_reg[gi];
        next_act[gi] = act[gi];
        next_pd[gi] = pd[gi];
        if (wr_in && mask[gi]) begin
          next_in[gi] = cmd_data;
        end
        if (upd_v[gi]) begin
          next_act[gi] = next_in[gi];
          next_pd[gi] = 1'b0;
        end else if (pdm[gi]) begin
          next_pd[gi] = 1'b1;
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          in_reg[gi] <= POR_CODE;
          act[gi] <= POR_CODE;
          pd[gi] <= POR_OPEN_OUT;
        end else begin
          in_reg[gi] <= next_in[gi];
          act[gi] <= next_act[gi];
          pd[gi] <= next_pd[gi];
        end
      end

      assign pd_vec[gi] = pd[gi];
      assign CH_DRIVE[gi] = !pd[gi];
      assign ACTIVE_CODE[gi*16 +: 16] = act[gi];

      a_hiz_keeps_code: assert property (pd[gi] && !upd_v[gi]
        |=> $stable(act[gi]) && pd[gi])
        else $error("powered-down channel changed");
      a_update_powers: assert property (upd_v[gi]
        |=> !pd[gi] && act[gi] == in_reg[gi])
        else $error("update did not power up or copy");
    end
  endgenerate

  // Reference mode, reference power and settle timer
  assign wake = |(upd_v & pd_vec);
  assign all_off = (&pd_vec) && !ref_on;

  always_comb begin
    next_ref_ext = ref_ext;
    next_ref_on = ref_on;
    next_ref_src = ref_src;
    next_settle = settle;
    if (settle != 10'h000) begin
      next_settle = settle - 10'h001;
    end
    if (exec && code == `QDRPC_CMD_REF_INT) begin
      next_ref_ext = 1'b0;
      next_ref_on = 1'b1;
    end else if (exec && code == `QDRPC_CMD_REF_EXT) begin
      next_ref_ext = 1'b1;
      next_ref_on = 1'b0;
      next_ref_src = QDRPC_SRC_EXT;
    end else if (exec && code == `QDRPC_CMD_PD_CHIP) begin
      next_ref_on = 1'b0;
      next_ref_src = QDRPC_SRC_CHIP;
    end
    // Only a chip power-down lets channel updates wake the reference
    if (|upd_v && !ref_on && next_ref_src == QDRPC_SRC_CHIP && !next_ref_ext) begin
      next_ref_on = 1'b1;
    end
    if (wake) begin
      next_settle = all_off ? 10'(LONG_CYC) : 10'(SHORT_CYC);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ref_ext <= POR_EXT_REF;
      ref_on <= !POR_EXT_REF;
      ref_src <= QDRPC_SRC_EXT;
      settle <= 10'h000;
    end else begin
      ref_ext <= next_ref_ext;
      ref_on <= next_ref_on;
      ref_src <= next_ref_src;
      settle <= next_settle;
    end
  end

  assign REF_EXT = ref_ext;
  assign REF_DRIVE = ref_on;
  assign BIAS_ON = !all_off;
  assign SETTLE_BUSY = (settle != 10'h000);

  // Reference commands and power-on state
  a_ref_int_sel: assert property (exec && code == `QDRPC_CMD_REF_INT
    |=> !REF_EXT && REF_DRIVE)
    else $error("internal reference not selected");
  a_ref_ext_sel: assert property (exec && code == `QDRPC_CMD_REF_EXT
    |=> REF_EXT && !REF_DRIVE)
    else $error("external reference not selected");
  a_ref_keeps_chan: assert property (exec && !load_act
    && (code == `QDRPC_CMD_REF_INT || code == `QDRPC_CMD_REF_EXT)
    |=> $stable(pd_vec) && $stable(ACTIVE_CODE))
    else $error("reference command touched a channel");
  a_por_outputs: assert property ($rose(RST_N)
    |-> CH_DRIVE == {4{!POR_OPEN_OUT}} && REF_EXT == POR_EXT_REF
    && REF_DRIVE == !POR_EXT_REF)
    else $error("power-on output state wrong");

  // Power-down commands
  a_pd_chan_cmd: assert property (exec && code == `QDRPC_CMD_PD_CHAN
    && !load_act |=> (~CH_DRIVE & $past(mask)) == $past(mask))
    else $error("addressed channel not powered down");
  a_pd_others_kept: assert property (exec && code == `QDRPC_CMD_PD_CHAN
    && !load_act |=> (CH_DRIVE | $past(mask)) == ($past(CH_DRIVE) | $past(mask)))
    else $error("power-down touched another channel");
  a_pd_chip_cmd: assert property (exec && code == `QDRPC_CMD_PD_CHIP
    && !load_act |=> CH_DRIVE == 4'h0 && !REF_DRIVE ##1 !BIAS_ON)
    else $error("chip power-down incomplete");
  a_pd_data_kept: assert property (exec && (code == `QDRPC_CMD_PD_CHAN
    || code == `QDRPC_CMD_PD_CHIP) |=> $stable(in_reg[0]) && $stable(in_reg[1])
    && $stable(in_reg[2]) && $stable(in_reg[3]))
    else $error("power-down touched data");
  a_bias_state: assert property (BIAS_ON == (REF_DRIVE || CH_DRIVE != 4'h0))
    else $error("bias state does not match power state");

  // Update, load pin and power-up delay
  a_load_pin_up: assert property (load_act |=> CH_DRIVE == 4'hf)
    else $error("load pin did not power channels");
  a_load_filter: assert property ($changed(ld_n)
    |-> $past(ld_s2) == $past(ld_s3) && ld_n == $past(ld_s3))
    else $error("load pin filter took a single sample");
  a_upd_all_up: assert property (exec && code == `QDRPC_CMD_WRITE_UPD_ALL
    |=> CH_DRIVE == 4'hf)
    else $error("update all left a channel down");
  a_settle_short: assert property (wake && !all_off
    |=> settle == 10'(SHORT_CYC) ##1 SETTLE_BUSY)
    else $error("short power-up delay wrong");
  a_settle_long: assert property (wake && all_off
    |=> settle == 10'(LONG_CYC) ##1 SETTLE_BUSY)
    else $error("long power-up delay wrong");
  a_settle_count: assert property (SETTLE_BUSY && !wake
    |=> settle == $past(settle) - 10'h001)
    else $error("power-up delay not counting down");
  a_settle_idle: assert property (!SETTLE_BUSY && !wake
    |=> !SETTLE_BUSY)
    else $error("power-up delay started without a wake");

  // Reference wake depends on what shut it off
  a_ref_ext_hold: assert property (!ref_on && ref_src == QDRPC_SRC_EXT
    && !(exec && code == `QDRPC_CMD_REF_INT) |=> !REF_DRIVE)
    else $error("reference woke without internal select");
  a_ref_chip_wake: assert property (!ref_on && ref_src == QDRPC_SRC_CHIP
    && !ref_ext && |upd_v && !(exec && code == `QDRPC_CMD_REF_EXT) |=> REF_DRIVE)
    else $error("reference did not wake with channels");

  // Ignored, idle and read accesses
  a_reserved_drop: assert property (cmd_go && !(chan_ok && code_ok) && !load_act
    |=> $stable(pd_vec) && $stable(ref_ext) && $stable(ref_on) && $stable(ACTIVE_CODE)
    && $stable(in_reg[0]) && $stable(in_reg[1]) && $stable(in_reg[2]) && $stable(in_reg[3]))
    else $error("reserved command had an effect");
  a_nop_no_effect: assert property (exec && code == `QDRPC_CMD_NOP
    && !load_act |=> $stable(pd_vec) && $stable(ref_on) && $stable(ref_ext)
    && $stable(ACTIVE_CODE))
    else $error("no-op command had an effect");
  a_write_no_update: assert property (exec && code == `QDRPC_CMD_WRITE
    && !load_act |=> $stable(ACTIVE_CODE) && $stable(pd_vec))
    else $error("input write changed an output");
  a_read_stands: assert property (AVS_READ && !AVS_WAITREQUEST
    |-> AVS_READDATA == $past(rd_mux))
    else $error("read data not from the addressed register");

endmodule : qdrpc_top

// >>> bench/qdrpc_host.sv
// Purpose: Host controller model, master on the Avalon-MM command port
// Assumes: Slave answers by dropping waitrequest
// Notes: The testbench calls the tasks by hierarchical name
`include "qdrpc_cfg.svh"

module qdrpc_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_rd

  // One write: command byte in bits 23:16, data word below it
  task automatic send(input logic [3:0] code, input logic [3:0] chan, input logic [15:0] data);
    bus_wr(`QDRPC_OFS_CMD, {8'h00, code, chan, data});
  endtask : send
endmodule : qdrpc_host

// >>> bench/qdrpc_top_tb.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Host model drives the command port
// Notes: Second instance runs the open-output, external-default option
`include "qdrpc_cfg.svh"

module qdrpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rd, wr, wait_req, load_n;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] be, ch_drive, ch_drive_oo;
  logic [63:0] active;
  logic ref_drive, ref_ext, bias_on, busy, ref_drive_oo, ref_ext_oo;
  int failures = 0;
  int checked = 0;
  int n;

  qdrpc_host u_qdrpc_host (.clk(clk), .address(addr), .read(rd), .write(wr),
    .writedata(wdata), .byteenable(be), .readdata(rdata), .waitrequest(wait_req));

  qdrpc_top u_qdrpc_top (.CLK_SYS(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .ASYNC_LOAD_N(load_n),
    .ACTIVE_CODE(active), .CH_DRIVE(ch_drive), .REF_DRIVE(ref_drive),
    .REF_EXT(ref_ext), .BIAS_ON(bias_on), .SETTLE_BUSY(busy));

  qdrpc_top #(.POR_EXT_REF(1'b1), .POR_OPEN_OUT(1'b1)) u_qdrpc_top_oo (.CLK_SYS(clk),
    .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(), .AVS_WAITREQUEST(),
    .ASYNC_LOAD_N(load_n), .ACTIVE_CODE(), .CH_DRIVE(ch_drive_oo),
    .REF_DRIVE(ref_drive_oo), .REF_EXT(ref_ext_oo), .BIAS_ON(), .SETTLE_BUSY());

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Counts cycles with the settle flag up, bounded
  task automatic settle(output int cnt);
    cnt = 0;
    repeat (1000) begin
      @(posedge clk);
      if (busy === 1'b1) cnt++;
    end
  endtask : settle

  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    load_n = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    u_qdrpc_host.bus_rd(`QDRPC_OFS_STAT, d);
    chk(d, 32'h60);
    chk({ch_drive, ch_drive_oo}, 8'hf0);
    chk({ref_ext_oo, ref_drive_oo}, 2'b10);
    u_qdrpc_host.send(4'h0, 4'h1, 16'h1234);
    u_qdrpc_host.bus_rd(`QDRPC_OFS_CH1, d);
    chk(d, 32'h00001234);
    u_qdrpc_host.send(4'h4, 4'h2, 16'hffff);
    u_qdrpc_host.bus_rd(`QDRPC_OFS_CH2, d);
    chk(d, 32'h0);
    chk({ch_drive, ch_drive_oo}, 8'hb0);
    u_qdrpc_host.send(4'h3, 4'h2, 16'h0055);
    settle(n);
    chk(n, 500);
    chk({ch_drive, ch_drive_oo, active[47:32]}, 24'hf40055);
    u_qdrpc_host.send(4'h7, 4'h0, 16'h0);
    @(posedge clk);
    chk({ref_ext, ref_drive}, 2'b10);
    u_qdrpc_host.send(4'h1, 4'hf, 16'h0);
    @(posedge clk);
    chk(ref_drive, 1'b0);
    u_qdrpc_host.send(4'h6, 4'h0, 16'h0);
    @(posedge clk);
    chk({ref_ext, ref_drive, ref_ext_oo}, 3'b010);
    u_qdrpc_host.send(4'h5, 4'hf, 16'h0);
    @(posedge clk);
    chk({ch_drive, ref_drive, bias_on}, 6'h00);
    u_qdrpc_host.send(4'h2, 4'h0, 16'h0abc);
    settle(n);
    chk(n, 600);
    chk({ch_drive, ref_drive, bias_on}, 6'h3f);
    chk(active, 64'h0000005512340abc);
    // Reserved command, reserved channel, then the no-op
    u_qdrpc_host.send(4'h8, 4'h0, 16'hffff);
    u_qdrpc_host.send(4'h0, 4'h5, 16'hffff);
    u_qdrpc_host.send(4'hf, 4'h0, 16'hffff);
    u_qdrpc_host.bus_rd(`QDRPC_OFS_CH0, d);
    chk(d, 32'h0abc0abc);
    u_qdrpc_host.send(4'h0, 4'h3, 16'h0777);
    u_qdrpc_host.send(4'h4, 4'hf, 16'h0);
    @(posedge clk);
    chk(ch_drive, 4'h0);
    load_n <= 1'b0;
    repeat (6) @(posedge clk);
    load_n <= 1'b1;
    @(posedge clk);
    chk({ch_drive, active[63:48]}, 20'hf0777);
    u_qdrpc_host.bus_rd(5'h1c, d);
    chk(d, 32'h0);
    // External select, chip down, update: reference stays off
    u_qdrpc_host.send(4'h7, 4'h0, 16'h0);
    u_qdrpc_host.send(4'h5, 4'hf, 16'h0);
    u_qdrpc_host.send(4'h1, 4'hf, 16'h0);
    @(posedge clk);
    chk({ch_drive, ref_ext, ref_drive, bias_on}, 7'h7d);
    end_sim();
  end
endmodule : qdrpc_top_tb
